// >>> hw/lpmc_axil_slave.sv
`timescale 1ns/1ps
module lpmc_axil_slave (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // write address and data
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // read address and data
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // register side
   output logic wr_en,
   output logic [7:0] wr_addr,
   output logic [7:0] wr_data,
   input wire logic wr_err,
   output logic rd_en,
   output logic [7:0] rd_addr,
   input wire logic [31:0] rd_data,
   input wire logic rd_err
);

   logic aw_full_r;
   logic w_full_r;
   logic [7:0] aw_r;
   logic [7:0] wd_r;

   assign s_axi_awready = ~aw_full_r;
   assign s_axi_wready = ~w_full_r;
   assign s_axi_arready = ~s_axi_rvalid;
   assign wr_en = aw_full_r & w_full_r & ~s_axi_bvalid;
   assign wr_addr = aw_r;
   assign wr_data = wd_r;
   assign rd_en = s_axi_arvalid & ~s_axi_rvalid;
   assign rd_addr = s_axi_araddr;

   // address and data may arrive in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_r <= 1'b0;
         aw_r <= 8'h00;
      end else if (s_axi_awvalid && !aw_full_r) begin
         aw_full_r <= 1'b1;
         aw_r <= s_axi_awaddr;
      end else if (wr_en) begin
         aw_full_r <= 1'b0;
      end
   end

   // only lane 0 carries register bits; a masked lane writes zero
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_full_r <= 1'b0;
         wd_r <= 8'h00;
      end else if (s_axi_wvalid && !w_full_r) begin
         w_full_r <= 1'b1;
         wd_r <= s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00;
      end else if (wr_en) begin
         w_full_r <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= lpmc_pkg::RESP_OKAY;
      end else if (wr_en) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_err ? lpmc_pkg::RESP_SLVERR : lpmc_pkg::RESP_OKAY;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= lpmc_pkg::RESP_OKAY;
      end else if (rd_en) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_data;
         s_axi_rresp <= rd_err ? lpmc_pkg::RESP_SLVERR : lpmc_pkg::RESP_OKAY;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule : lpmc_axil_slave

// >>> hw/lpmc_fall_sync.sv
`timescale 1ns/1ps
module lpmc_fall_sync (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // asynchronous level in, synchronous event out
   input wire logic async_in,
   output logic fall_pulse
);

   logic meta_r;
   logic sync_r;
   logic prev_r;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta_r <= 1'b0;
         sync_r <= 1'b0;
         prev_r <= 1'b0;
      end else begin
         meta_r <= async_in;
         sync_r <= meta_r;
         prev_r <= sync_r;
      end
   end

   assign fall_pulse = prev_r & ~sync_r;

endmodule : lpmc_fall_sync

// >>> hw/lpmc_pkg.sv
package lpmc_pkg;

   // register byte offsets
   localparam logic [7:0] SCR2_OFFSET = 8'h00;
   localparam logic [7:0] TBCR_OFFSET = 8'h04;
   localparam logic [7:0] STAT_OFFSET = 8'h08;

   // system_control_two_register fields
   localparam int SCR2_XEN_BIT = 7;
   localparam int SCR2_XTEN_BIT = 6;
   localparam int SCR2_SYSCK_BIT = 5;
   localparam int SCR2_CPU_HALT_BIT = 4;
   localparam int SCR2_TG_STOP_BIT = 2;
   localparam logic [7:0] SCR2_RESET = 8'h80;
   localparam logic [7:0] SCR2_RW_MASK = 8'hf4;

   // time_base_control_register fields
   localparam int TBCR_EN_BIT = 3;
   localparam int TBCR_SEL_LSB = 0;
   localparam int TBCR_SEL_W = 3;
   localparam logic [7:0] TBCR_RESET = 8'h00;
   localparam logic [7:0] TBCR_RW_MASK = 8'h0f;

   // interrupt latch index of the time base source
   localparam int TB_IRQ_IDX = 7;
   localparam int IRQ_W = 16;
   localparam int PC_W = 16;
   localparam logic [15:0] PC_STEP = 16'h0002;

   // axi responses
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   typedef enum logic [1:0] {
      LPMC_RUN = 2'b00,
      LPMC_CPU_HALT = 2'b01,
      LPMC_TG_HALT = 2'b10,
      LPMC_WAKE = 2'b11
   } lpmc_state_t;

endpackage : lpmc_pkg

// >>> hw/lpmc_top.sv
// Added by the designer: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
// Summary of operation
// RULE1 - cpu-halt modes stop processor and watchdog, peripherals keep clocks
// RULE2 - all halt modes freeze memory, registers, status word, port latches
// RULE3 - resume address is two bytes past the mode-start instruction
// RULE4 - software clears master enable, sets wake enables, writes cpu-halt bit
// RULE5 - leaving cpu-halt clears its bit and restores previous mode
// RULE6 - external reset ends any low-power mode; restart in fast-only mode
// RULE7 - master enable 0: enabled interrupt wakes, resumes at next instruction
// RULE8 - master enable 1: enabled interrupt wakes and is serviced first
// RULE9 - watchdog interrupt just before cpu-halt entry cancels the entry
// RULE10 - tg-halt modes gate all peripheral clocks except time base timer
// RULE11 - software stops peripherals, then writes tg-halt bit to enter
// RULE12 - leaving tg-halt clears its bit and restores previous mode
// RULE13 - tg-halt start with time base enabled sets time base latch
// RULE14 - and-term 0: time base source falling edge wakes, next instruction
// RULE15 - and-term 1: source falling edge wakes and services time base irq
// RULE16 - tg-halt entry and wake happen whatever time base enable says
// RULE17 - tg-halt wake follows asynchronous clock; may be shorter than period
// RULE18 - watchdog interrupt just before tg-halt entry cancels the entry
// RULE19 - software sets clock select, then clears fast oscillator enable
// RULE20 - software enables fast oscillator, waits warm-up, clears select
// RULE21 - after select clear, keep slow clock until clocks align, then switch
// RULE22 - software turns fast oscillator off before slow-to-stop transition
// RULE23 - illegal oscillator disable raises system clock reset
// RULE24 - software never sets both halt bits in one write
// RULE25 - gating changes only at instruction boundaries, synchronous to clock
module lpmc_top (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // cpu core
   input wire logic instr_boundary,
   input wire logic [15:0] instr_addr,
   input wire logic interrupt_master_enable,
   input wire logic watchdog_irq,
   output logic cpu_run_en,
   output logic watchdog_run_en,
   output logic state_hold,
   output logic [15:0] resume_pc,
   output logic wake_resume,
   output logic wake_service,
   // interrupt logic
   input wire logic [15:0] individual_interrupt_enable,
   input wire logic [15:0] interrupt_request_latch,
   output logic set_time_base_latch,
   // timing generator and time base timer
   input wire logic [7:0] time_base_taps,
   output logic periph_clk_en,
   output logic time_base_clk_en,
   // oscillators and clock switch
   input wire logic lf_clk_in,
   output logic hf_osc_en,
   output logic lf_osc_en,
   output logic sysclk_is_slow,
   output logic sys_clk_reset
);

   lpmc_pkg::lpmc_state_t state_r;
   lpmc_pkg::lpmc_state_t state_nxt;

   logic [7:0] scr2_r;
   logic [7:0] tbcr_r;
   logic [15:0] resume_pc_r;
   logic wake_resume_r;
   logic wake_service_r;
   logic set_tb_latch_r;
   logic slow_active_r;
   logic sys_clk_reset_r;
   logic service_pending_r;

   logic wr_en;
   logic [7:0] wr_addr;
   logic [7:0] wr_data;
   logic wr_err;
   logic rd_en;
   logic [7:0] rd_addr;
   logic [31:0] rd_data;
   logic rd_err;

   logic scr2_wr;
   logic tbcr_wr;
   logic [7:0] scr2_wval;
   logic tb_src_sel;
   logic tb_fall;
   logic lf_fall;
   logic cpu_halt_req;
   logic tg_halt_req;
   logic tb_enable;
   logic cpu_wake;
   logic tb_service;
   logic enter_cpu_halt;
   logic enter_tg_halt;
   logic cancel_halt;
   logic leave_halt;

   lpmc_axil_slave u_bus (
      .aclk(aclk),
      .aresetn(aresetn),
      .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready),
      .wr_en(wr_en),
      .wr_addr(wr_addr),
      .wr_data(wr_data),
      .wr_err(wr_err),
      .rd_en(rd_en),
      .rd_addr(rd_addr),
      .rd_data(rd_data),
      .rd_err(rd_err)
   );

   // the tap mux sits ahead of the synchroniser; a select change while
   // halted may fake an edge, which only ends the halt early
   assign tb_src_sel = time_base_taps[tbcr_r[lpmc_pkg::TBCR_SEL_LSB +:
                                             lpmc_pkg::TBCR_SEL_W]];

   lpmc_fall_sync u_tb_edge (
      .aclk(aclk),
      .aresetn(aresetn),
      .async_in(tb_src_sel),
      .fall_pulse(tb_fall)
   );

   lpmc_fall_sync u_lf_edge (
      .aclk(aclk),
      .aresetn(aresetn),
      .async_in(lf_clk_in),
      .fall_pulse(lf_fall)
   );

   assign scr2_wr = wr_en && (wr_addr == lpmc_pkg::SCR2_OFFSET);
   assign tbcr_wr = wr_en && (wr_addr == lpmc_pkg::TBCR_OFFSET);
   assign wr_err = !(wr_addr == lpmc_pkg::SCR2_OFFSET ||
                     wr_addr == lpmc_pkg::TBCR_OFFSET ||
                     wr_addr == lpmc_pkg::STAT_OFFSET);
   assign rd_err = !(rd_addr == lpmc_pkg::SCR2_OFFSET ||
                     rd_addr == lpmc_pkg::TBCR_OFFSET ||
                     rd_addr == lpmc_pkg::STAT_OFFSET);
   assign scr2_wval = wr_data & lpmc_pkg::SCR2_RW_MASK;

   always_comb begin
      rd_data = 32'h0000_0000;
      case (rd_addr)
         lpmc_pkg::SCR2_OFFSET: rd_data[7:0] = scr2_r;
         lpmc_pkg::TBCR_OFFSET: rd_data[7:0] = tbcr_r;
         lpmc_pkg::STAT_OFFSET: begin
            rd_data[1:0] = state_r;
            rd_data[2] = slow_active_r;
            rd_data[3] = service_pending_r;
         end
         default: rd_data = 32'h0000_0000;
      endcase
   end

   assign cpu_halt_req = scr2_r[lpmc_pkg::SCR2_CPU_HALT_BIT];
   assign tg_halt_req = scr2_r[lpmc_pkg::SCR2_TG_STOP_BIT];
   assign tb_enable = tbcr_r[lpmc_pkg::TBCR_EN_BIT];

   // a pending watchdog interrupt at the boundary wins over the halt
   assign cancel_halt = (state_r == lpmc_pkg::LPMC_RUN) && instr_boundary &&
                        watchdog_irq && (cpu_halt_req || tg_halt_req); // RULE9 RULE18
   assign enter_cpu_halt = (state_r == lpmc_pkg::LPMC_RUN) &&
                           instr_boundary && !watchdog_irq &&
                           cpu_halt_req; // RULE4 RULE25
   // cpu-halt takes precedence if software breaks the one-bit-per-write rule
   assign enter_tg_halt = (state_r == lpmc_pkg::LPMC_RUN) &&
                          instr_boundary && !watchdog_irq &&
                          !cpu_halt_req && tg_halt_req; // RULE11 RULE16 RULE24
   assign cpu_wake = |(interrupt_request_latch &
                       individual_interrupt_enable); // RULE7 RULE8
   assign tb_service = interrupt_master_enable &&
                       individual_interrupt_enable[lpmc_pkg::TB_IRQ_IDX] &&
                       tb_enable; // RULE14 RULE15
   assign leave_halt = ((state_r == lpmc_pkg::LPMC_CPU_HALT) && cpu_wake) ||
                       ((state_r == lpmc_pkg::LPMC_TG_HALT) && tb_fall); // RULE17

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         lpmc_pkg::LPMC_RUN: begin
            if (enter_cpu_halt) begin
               state_nxt = lpmc_pkg::LPMC_CPU_HALT;
            end else if (enter_tg_halt) begin
               state_nxt = lpmc_pkg::LPMC_TG_HALT;
            end
         end
         lpmc_pkg::LPMC_CPU_HALT: begin
            if (cpu_wake) begin
               state_nxt = lpmc_pkg::LPMC_WAKE;
            end
         end
         lpmc_pkg::LPMC_TG_HALT: begin
            if (tb_fall) begin
               state_nxt = lpmc_pkg::LPMC_WAKE; // RULE16
            end
         end
         lpmc_pkg::LPMC_WAKE: state_nxt = lpmc_pkg::LPMC_RUN;
         default: state_nxt = lpmc_pkg::LPMC_RUN;
      endcase
   end

   // synchronous reset drops any halt and restarts in fast-only mode
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_r <= lpmc_pkg::LPMC_RUN; // RULE6
      end else begin
         state_r <= state_nxt;
      end
   end

   // a software write in the same cycle as the hardware clear wins
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         scr2_r <= lpmc_pkg::SCR2_RESET; // RULE6
      end else if (scr2_wr) begin
         scr2_r <= scr2_wval; // RULE19 RULE20 RULE22
      end else if (leave_halt || cancel_halt) begin
         scr2_r[lpmc_pkg::SCR2_CPU_HALT_BIT] <= 1'b0; // RULE5
         scr2_r[lpmc_pkg::SCR2_TG_STOP_BIT] <= 1'b0; // RULE12
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tbcr_r <= lpmc_pkg::TBCR_RESET;
      end else if (tbcr_wr) begin
         tbcr_r <= wr_data & lpmc_pkg::TBCR_RW_MASK;
      end
   end

   // resume address captured at the start instruction
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         resume_pc_r <= 16'h0000;
      end else if (enter_cpu_halt || enter_tg_halt) begin
         resume_pc_r <= instr_addr + lpmc_pkg::PC_STEP; // RULE3
      end
   end

   // service decision is latched at wake time so the cpu sees one answer
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         service_pending_r <= 1'b0;
      end else if ((state_r == lpmc_pkg::LPMC_CPU_HALT) && cpu_wake) begin
         service_pending_r <= interrupt_master_enable; // RULE7 RULE8
      end else if ((state_r == lpmc_pkg::LPMC_TG_HALT) && tb_fall) begin
         service_pending_r <= tb_service; // RULE14 RULE15
      end else if (state_r == lpmc_pkg::LPMC_WAKE) begin
         service_pending_r <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wake_resume_r <= 1'b0;
         wake_service_r <= 1'b0;
      end else begin
         wake_resume_r <= (state_r == lpmc_pkg::LPMC_WAKE) &&
                          !service_pending_r; // RULE7 RULE14
         wake_service_r <= (state_r == lpmc_pkg::LPMC_WAKE) &&
                           service_pending_r; // RULE8 RULE15
      end
   end

   // time base latch is set as the tg-halt starts, not at wake
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         set_tb_latch_r <= 1'b0;
      end else begin
         set_tb_latch_r <= enter_tg_halt && tb_enable; // RULE13
      end
   end

   // switch only on a slow clock falling edge so no runt cycle reaches
   // the core; this costs up to one slow period of latency
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         slow_active_r <= 1'b0;
      end else if (lf_fall) begin
         slow_active_r <= scr2_r[lpmc_pkg::SCR2_SYSCK_BIT]; // RULE21 RULE25
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sys_clk_reset_r <= 1'b0;
      end else begin
         sys_clk_reset_r <= scr2_wr &&
            ((!scr2_wval[lpmc_pkg::SCR2_XEN_BIT] &&
              !scr2_wval[lpmc_pkg::SCR2_XTEN_BIT]) ||
             (!scr2_wval[lpmc_pkg::SCR2_XEN_BIT] &&
              !scr2_r[lpmc_pkg::SCR2_SYSCK_BIT]) ||
             (!scr2_wval[lpmc_pkg::SCR2_XTEN_BIT] &&
              scr2_r[lpmc_pkg::SCR2_SYSCK_BIT])); // RULE23
      end
   end

   assign cpu_run_en = (state_r == lpmc_pkg::LPMC_RUN) ||
                       (state_r == lpmc_pkg::LPMC_WAKE); // RULE1
   assign watchdog_run_en = cpu_run_en; // RULE1
   assign state_hold = !cpu_run_en; // RULE2
   assign periph_clk_en = (state_r != lpmc_pkg::LPMC_TG_HALT); // RULE10
   assign time_base_clk_en = 1'b1; // RULE10
   assign resume_pc = resume_pc_r;
   assign wake_resume = wake_resume_r;
   assign wake_service = wake_service_r;
   assign set_time_base_latch = set_tb_latch_r;
   assign hf_osc_en = scr2_r[lpmc_pkg::SCR2_XEN_BIT];
   assign lf_osc_en = scr2_r[lpmc_pkg::SCR2_XTEN_BIT];
   assign sysclk_is_slow = slow_active_r;
   assign sys_clk_reset = sys_clk_reset_r;

endmodule : lpmc_top

// >>> test/lpmc_core_model.sv
`timescale 1ns/1ps
module lpmc_core_model (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // run control
   input wire logic cpu_run_en,
   // instruction stream and source clocks
   output logic instr_boundary,
   output logic [15:0] instr_addr,
   output logic [7:0] time_base_taps,
   output logic lf_clk_in
);
   logic [1:0] phase_r;
   logic [7:0] tap_cnt_r = 8'h00;
   logic lf_r = 1'b0;
   // two-byte instructions, one boundary every fourth cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         phase_r <= 2'h0;
         instr_addr <= 16'h0100;
      end else if (cpu_run_en) begin
         phase_r <= phase_r + 2'h1;
         if (instr_boundary) instr_addr <= instr_addr + 16'h0002;
      end
   end
   assign instr_boundary = cpu_run_en && (phase_r == 2'h3);
   // unrelated periods so wake edges land at any phase of aclk
   always #23 tap_cnt_r = tap_cnt_r + 8'h01;
   always #61 lf_r = !lf_r;
   assign time_base_taps = tap_cnt_r;
   assign lf_clk_in = lf_r;
endmodule : lpmc_core_model

// >>> test/lpmc_top_monitor.sv
`timescale 1ns/1ps
module lpmc_top_monitor (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // bus and core side
   input wire logic s_axi_bvalid,
   input wire logic instr_boundary,
   input wire logic [15:0] instr_addr,
   input wire logic interrupt_master_enable,
   input wire logic watchdog_irq,
   input wire logic cpu_run_en,
   input wire logic watchdog_run_en,
   input wire logic state_hold,
   input wire logic [15:0] resume_pc,
   input wire logic wake_resume,
   input wire logic wake_service,
   // clocks and interrupts
   input wire logic set_time_base_latch,
   input wire logic periph_clk_en,
   input wire logic time_base_clk_en,
   input wire logic sys_clk_reset
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_halt_stops_core:
      assert property (!cpu_run_en |-> !watchdog_run_en && state_hold)
      else $error("core runs while halted");
   a_entry_at_boundary:
      assert property ($fell(cpu_run_en) |-> $past(instr_boundary))
      else $error("halt entered off a boundary");
   a_resume_pc_step:
      assert property ($fell(cpu_run_en) |->
         resume_pc == $past(instr_addr) + 16'h0002)
      else $error("resume address wrong");
   a_wdog_blocks_entry:
      assert property (cpu_run_en && instr_boundary && watchdog_irq |=>
         cpu_run_en && periph_clk_en)
      else $error("halt entered despite watchdog");
   a_tg_gates_periph:
      assert property (!periph_clk_en |-> !cpu_run_en && time_base_clk_en)
      else $error("gating wrong in timing halt");
   a_tb_latch_halt:
      assert property (set_time_base_latch |->
         !periph_clk_en || !$past(periph_clk_en))
      else $error("time base latch set outside entry");
   a_wake_pulse_once:
      assert property (wake_resume || wake_service |->
         !(wake_resume && wake_service) ##1 !wake_resume && !wake_service)
      else $error("wake pulse malformed");
   a_exit_gives_wake:
      assert property ($rose(cpu_run_en) |=> wake_resume || wake_service)
      else $error("exit without wake pulse");
   a_service_needs_ime:
      assert property (wake_service |-> $past(interrupt_master_enable, 2))
      else $error("service without master enable");
   a_clk_reset_pulse:
      assert property (sys_clk_reset |->
         (s_axi_bvalid || $past(s_axi_bvalid)) ##1 !sys_clk_reset)
      else $error("clock reset not tied to a write");
   c_cpu_halt: cover property ($fell(cpu_run_en) && periph_clk_en);
   c_tg_halt: cover property ($fell(periph_clk_en));
   c_service: cover property (wake_service);
   c_clk_reset: cover property (sys_clk_reset);
endmodule : lpmc_top_monitor

bind lpmc_top lpmc_top_monitor i_lpmc_top_monitor (.*);

// >>> test/tb.sv
`timescale 1ns/1ps
module tb;
   localparam logic [7:0] scr2 = lpmc_pkg::SCR2_OFFSET;
   localparam logic [7:0] tbcr = lpmc_pkg::TBCR_OFFSET;
   localparam logic [1:0] ok = lpmc_pkg::RESP_OKAY;
   localparam logic [1:0] bad = lpmc_pkg::RESP_SLVERR;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00;
   logic [7:0] s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'h1;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b1;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b1;
   logic interrupt_master_enable = 1'b0, watchdog_irq = 1'b0;
   logic [15:0] individual_interrupt_enable = 16'h0000;
   logic [15:0] interrupt_request_latch = 16'h0000;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, instr_boundary, lf_clk_in;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic [15:0] instr_addr, resume_pc, last_addr;
   logic [7:0] time_base_taps;
   logic cpu_run_en, watchdog_run_en, state_hold, wake_resume, wake_service;
   logic set_time_base_latch, periph_clk_en, time_base_clk_en;
   logic hf_osc_en, lf_osc_en, sysclk_is_slow, sys_clk_reset;
   int errors = 0, checked = 0, n_lat = 0, n_rst = 0;

   always #5 aclk = ~aclk;
   always @(posedge aclk) begin
      if (set_time_base_latch === 1'b1) n_lat++;
      if (sys_clk_reset === 1'b1) n_rst++;
      if (instr_boundary === 1'b1 && cpu_run_en === 1'b1) last_addr = instr_addr;
   end

   lpmc_top i_lpmc_top (.*);
   lpmc_core_model i_lpmc_core_model (.*);

   task automatic finish_test;
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : finish_test

   task automatic chk(input string what, input logic [31:0] exp,
         input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic axw(input logic [7:0] a, input logic [7:0] d,
         input logic [1:0] er);
      int i;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      for (i = 0; i < 50; i++) begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid === 1'b1) break;
      end
      if (i == 50) begin chk("bvalid", 1, 0); finish_test(); end
      chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
   endtask : axw

   task automatic axr(input logic [7:0] a, input logic [7:0] d,
         input logic [1:0] er);
      int i;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      for (i = 0; i < 50; i++) begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid === 1'b1) break;
      end
      if (i == 50) begin chk("rvalid", 1, 0); finish_test(); end
      chk("rdata", {24'h0, d}, s_axi_rdata);
      chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
   endtask : axr

   task automatic wt(input int k);
      int i;
      for (i = 0; i < 500; i++) begin
         @(posedge aclk);
         if (k == 0 && cpu_run_en === 1'b0) break;
         if (k == 1 && periph_clk_en === 1'b0) break;
         if (k == 2 && (wake_resume | wake_service) === 1'b1) break;
         if (k == 3 && sysclk_is_slow === 1'b1) break;
         if (k == 4 && sysclk_is_slow === 1'b0) break;
      end
      if (i == 500) begin chk("wait", 1, 0); finish_test(); end
   endtask : wt

   task automatic t_reset;
      chk("run", 1, {31'h0, cpu_run_en});
      axr(scr2, lpmc_pkg::SCR2_RESET, ok);
      axr(tbcr, lpmc_pkg::TBCR_RESET, ok);
      axw(8'h0c, 8'hff, bad);
      axr(8'h0c, 8'h00, bad);
      $display("t_reset done");
   endtask : t_reset

   task automatic t_cpu_halt(input logic ime);
      interrupt_master_enable <= ime;
      individual_interrupt_enable <= 16'h0010;
      axw(scr2, 8'h90, ok);
      wt(0);
      chk("watchdog", 0, {31'h0, watchdog_run_en});
      chk("periph", 1, {31'h0, periph_clk_en});
      chk("resume pc", {16'h0, last_addr + 16'h0002}, {16'h0, resume_pc});
      interrupt_request_latch <= 16'h0010;
      wt(2);
      chk("service", {31'h0, ime}, {31'h0, wake_service});
      chk("resume", {31'h0, !ime}, {31'h0, wake_resume});
      interrupt_request_latch <= 16'h0000;
      axr(scr2, 8'h80, ok);
      $display("t_cpu_halt done");
   endtask : t_cpu_halt

   task automatic t_wdog(input logic [7:0] v);
      watchdog_irq <= 1'b1;
      axw(scr2, v, ok);
      repeat (12) @(posedge aclk);
      chk("run", 1, {31'h0, cpu_run_en & periph_clk_en});
      watchdog_irq <= 1'b0;
      axr(scr2, 8'h80, ok);
      $display("t_wdog done");
   endtask : t_wdog

   task automatic t_tg(input logic ten);
      int n0;
      interrupt_master_enable <= 1'b1;
      individual_interrupt_enable <= 16'h0080;
      axw(tbcr, {4'h0, ten, 3'h3}, ok);
      n0 = n_lat;
      axw(scr2, 8'h84, ok);
      wt(1);
      chk("cpu", 0, {31'h0, cpu_run_en});
      chk("tb clk", 1, {31'h0, time_base_clk_en});
      wt(2);
      chk("service", {31'h0, ten}, {31'h0, wake_service});
      chk("latch pulses", {31'h0, ten}, n_lat - n0);
      axr(scr2, 8'h80, ok);
      $display("t_tg done");
   endtask : t_tg

   task automatic t_clk;
      int n0;
      n0 = n_rst;
      axw(scr2, 8'hc0, ok);
      axw(scr2, 8'he0, ok);
      wt(3);
      axw(scr2, 8'h60, ok);
      chk("osc", 1, {30'h0, hf_osc_en, lf_osc_en});
      axw(scr2, 8'he0, ok);
      chk("clock resets", 0, n_rst - n0);
      axw(scr2, 8'ha0, ok);
      axw(scr2, 8'he0, ok);
      chk("clock resets", 1, n_rst - n0);
      axw(scr2, 8'hc0, ok);
      chk("slow", 1, {31'h0, sysclk_is_slow});
      wt(4);
      axw(scr2, 8'h80, ok);
      axw(scr2, 8'h00, ok);
      repeat (2) @(posedge aclk);
      chk("clock resets", 2, n_rst - n0);
      $display("t_clk done");
   endtask : t_clk

   task automatic t_reset_exit;
      individual_interrupt_enable <= 16'h0000;
      axw(scr2, 8'h90, ok);
      wt(0);
      aresetn <= 1'b0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      chk("run", 1, {31'h0, cpu_run_en});
      chk("slow", 0, {31'h0, sysclk_is_slow});
      axr(scr2, 8'h80, ok);
      $display("t_reset_exit done");
   endtask : t_reset_exit

   initial begin
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset();
      t_cpu_halt(1'b0);
      t_cpu_halt(1'b1);
      t_wdog(8'h90);
      t_wdog(8'h84);
      t_tg(1'b0);
      t_tg(1'b1);
      t_clk();
      t_reset_exit();
      finish_test();
   end
endmodule : tb
